// ==== hw/psl_port_bits.sv ====
// Lamp and option-switch bits of a four-port serial expander.
// Assumes a bit-addressed host bus with one-cycle strobes on clock.
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Writing zero to a port's lamp bit lights that lamp.
// - Writing one darkens it; the lamp holds until written again.
// - Each port's lamp bit sits at displacement 36 from its base.
// - Auto-dial lamp at displacement 55 from port A base, zero lights.
// - Each of four ports has two readable option switches.
// - A closed switch reads one, an open switch reads zero.
// - Upper switch reads at displacement 37, lower at 36.
module psl_port_bits (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Host bit bus.
  input wire logic [psl_pkg::ADDR_W-1:0] cru_addr,
  input wire logic cru_wdata,
  input wire logic cru_we,
  input wire logic cru_re,
  output logic cru_rdata,
  // Option switch pins, one means closed.
  input wire logic [psl_pkg::SW_W-1:0] option_switch_pack,
  // Lamp drives, low lights the lamp.
  output logic port_a_lamp_b,
  output logic port_b_lamp_b,
  output logic port_c_lamp_b,
  output logic port_d_lamp_b,
  output logic autodial_lamp_b
);
  import psl_pkg::*;

  localparam logic [ADDR_W-1:0] BASES [NUM_PORTS] =
    '{PORT_A_BASE, PORT_B_BASE, PORT_C_BASE, PORT_D_BASE};

  psl_cru_if bus (
    .clock(clock),
    .rst_b(rst_b)
  );

  logic [NUM_PORTS-1:0] lamp_b;
  logic [SW_W-1:0] sw_level;
  logic rdata_q;
  logic rdata_d;

  assign bus.addr = cru_addr;
  assign bus.wdata = cru_wdata;
  assign bus.we = cru_we;

  // Per-port lamp bits, each decoded at its own base.
  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_lamp
    psl_lamp_bit #(
      .BIT_ADDR(BASES[p] + LAMP_DISP)
    ) u_lamp (
      .bus(bus),
      .lamp_b(lamp_b[p])
    );
  end

  psl_lamp_bit #(
    .BIT_ADDR(PORT_A_BASE + AUTODIAL_DISP)
  ) u_autodial (
    .bus(bus),
    .lamp_b(autodial_lamp_b)
  );

  assign port_a_lamp_b = lamp_b[0];
  assign port_b_lamp_b = lamp_b[1];
  assign port_c_lamp_b = lamp_b[2];
  assign port_d_lamp_b = lamp_b[3];

  // Switch pins are asynchronous and bounce, so they are synchronised.
  psl_sync2 #(
    .W(SW_W)
  ) u_sw_sync (
    .clock(clock),
    .rst_b(rst_b),
    .pin(option_switch_pack),
    .level(sw_level)
  );

  // Read decode: only switch bits answer; the lamp bits are write-only.
  always_comb
  begin
    rdata_d = RD_IDLE;
    if (cru_re)
    begin
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        if (cru_addr == BASES[p] + SW_LO_DISP)
        begin
          rdata_d = sw_level[SW_PER_PORT*p];
        end
        else if (cru_addr == BASES[p] + SW_HI_DISP)
        begin
          rdata_d = sw_level[SW_PER_PORT*p+1];
        end
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      rdata_q <= RD_IDLE;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  assign cru_rdata = rdata_q;

  // Checks that span the whole port map.
  for (genvar p = 0; p < NUM_PORTS; p++)
  begin : g_chk
    a_lower_switch_read: assert property (
      @(posedge clock) disable iff (!rst_b)
      (cru_re && cru_addr == BASES[p] + SW_LO_DISP)
        |=> cru_rdata == $past(sw_level[SW_PER_PORT*p]))
      else $error("lower switch read returned wrong level");

    a_upper_switch_read: assert property (
      @(posedge clock) disable iff (!rst_b)
      (cru_re && cru_addr == BASES[p] + SW_HI_DISP)
        |=> cru_rdata == $past(sw_level[SW_PER_PORT*p+1]))
      else $error("upper switch read returned wrong level");

    a_closed_reads_one: assert property (
      @(posedge clock) disable iff (!rst_b)
      (cru_re && cru_addr == BASES[p] + SW_HI_DISP
        && sw_level[SW_PER_PORT*p+1]) |=> cru_rdata)
      else $error("closed switch did not read one");

    a_lamp_write_local: assert property (
      @(posedge clock) disable iff (!rst_b)
      (cru_we && cru_addr != BASES[p] + LAMP_DISP) |=> $stable(lamp_b[p]))
      else $error("lamp changed by a write to another address");

    a_lamp_follows_write: assert property (
      @(posedge clock) disable iff (!rst_b)
      (cru_we && cru_addr == BASES[p] + LAMP_DISP)
        |=> lamp_b[p] == $past(cru_wdata))
      else $error("lamp did not follow the bit written to it");

    a_lamp_holds_idle: assert property (
      @(posedge clock) disable iff (!rst_b)
      !cru_we |=> $stable(lamp_b[p]))
      else $error("lamp changed with no write on the bus");

    a_read_keeps_lamp: assert property (
      @(posedge clock) disable iff (!rst_b)
      cru_re |=> $stable(lamp_b[p]))
      else $error("lamp changed by a read");

    a_lower_open_zero: assert property (
      @(posedge clock) disable iff (!rst_b)
      (cru_re && cru_addr == BASES[p] + SW_LO_DISP
        && !sw_level[SW_PER_PORT*p]) |=> !cru_rdata)
      else $error("open lower switch did not read zero");

    a_lower_closed_one: assert property (
      @(posedge clock) disable iff (!rst_b)
      (cru_re && cru_addr == BASES[p] + SW_LO_DISP
        && sw_level[SW_PER_PORT*p]) |=> cru_rdata)
      else $error("closed lower switch did not read one");

    a_upper_open_zero: assert property (
      @(posedge clock) disable iff (!rst_b)
      (cru_re && cru_addr == BASES[p] + SW_HI_DISP
        && !sw_level[SW_PER_PORT*p+1]) |=> !cru_rdata)
      else $error("open upper switch did not read zero");

    a_lamp_addr_switch: assert property (
      @(posedge clock) disable iff (!rst_b)
      (cru_re && cru_addr == BASES[p] + LAMP_DISP)
        |=> cru_rdata == $past(sw_level[SW_PER_PORT*p]))
      else $error("read at the lamp bit did not return the lower switch");

    a_write_then_read: assert property (
      @(posedge clock) disable iff (!rst_b)
      (cru_we && cru_addr == BASES[p] + LAMP_DISP) ##1
        (cru_re && cru_addr == BASES[p] + SW_LO_DISP)
        |=> cru_rdata == $past(sw_level[SW_PER_PORT*p]))
      else $error("lamp write disturbed the following switch read");
  end

  a_autodial_lights: assert property (
    @(posedge clock) disable iff (!rst_b)
    (cru_we && cru_addr == PORT_A_BASE + AUTODIAL_DISP)
      |=> autodial_lamp_b == $past(cru_wdata) && $stable(port_a_lamp_b))
    else $error("auto-dial lamp did not follow its write");

  a_write_keeps_switch: assert property (
    @(posedge clock) disable iff (!rst_b)
    (cru_we && cru_addr == PORT_A_BASE + LAMP_DISP) ##1
      (cru_re && cru_addr == PORT_A_BASE + SW_LO_DISP)
      |=> cru_rdata == $past(sw_level[0]))
    else $error("lamp write disturbed the switch read");

  a_rdata_one_cycle: assert property (
    @(posedge clock) disable iff (!rst_b)
    !cru_re |=> !cru_rdata)
    else $error("read data stood outside the read answer cycle");

  // Read decode kept apart from the read path, so the checks below do not reuse it.
  logic rd_mapped;

  always_comb
  begin
    rd_mapped = 1'h0;
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      if (cru_addr == BASES[p] + SW_LO_DISP || cru_addr == BASES[p] + SW_HI_DISP)
      begin
        rd_mapped = 1'h1;
      end
    end
  end

  a_unmapped_reads_zero: assert property (
    @(posedge clock) disable iff (!rst_b)
    (cru_re && !rd_mapped) |=> !cru_rdata)
    else $error("read of an unmapped bit did not return zero");

  a_autodial_no_switch: assert property (
    @(posedge clock) disable iff (!rst_b)
    (cru_re && cru_addr == PORT_A_BASE + AUTODIAL_DISP) |=> !cru_rdata)
    else $error("read at the auto-dial lamp bit returned a one");

  a_autodial_holds_idle: assert property (
    @(posedge clock) disable iff (!rst_b)
    !(cru_we && cru_addr == PORT_A_BASE + AUTODIAL_DISP) |=> $stable(autodial_lamp_b))
    else $error("auto-dial lamp changed without a write to its bit");

  a_switch_two_stages: assert property (
    @(posedge clock) disable iff (!rst_b)
    ($past(rst_b) && $past(rst_b, 2)) |-> sw_level == $past(option_switch_pack, 2))
    else $error("switch level did not pass exactly two stages");

  a_reset_lamps_dark: assert property (
    @(posedge clock)
    !rst_b |=> lamp_b == {NUM_PORTS{LAMP_OFF}} && autodial_lamp_b == LAMP_OFF)
    else $error("a lamp was not dark after reset");

  a_reset_rdata_zero: assert property (
    @(posedge clock)
    !rst_b |=> cru_rdata == RD_IDLE)
    else $error("read data was not idle after reset");

endmodule : psl_port_bits

`default_nettype wire

// ==== hw/psl_pkg.sv ====
// Constants for the per-port lamp and option-switch bits.
// Assumes a bit-addressed I/O space with 12-bit bit addresses.
package psl_pkg;

  // Width of a bit address in the serial I/O space.
  localparam int ADDR_W = 12;
  // Number of serial ports on the board.
  localparam int NUM_PORTS = 4;
  // Option switches per port.
  localparam int SW_PER_PORT = 2;
  // Width of the whole option switch pack.
  localparam int SW_W = NUM_PORTS * SW_PER_PORT;

  // Hardware base bit addresses of ports A to D, 64 bits apart.
  localparam logic [ADDR_W-1:0] PORT_A_BASE = 12'h100;
  localparam logic [ADDR_W-1:0] PORT_B_BASE = 12'h140;
  localparam logic [ADDR_W-1:0] PORT_C_BASE = 12'h180;
  localparam logic [ADDR_W-1:0] PORT_D_BASE = 12'h1c0;

  // Bit displacements from a port's hardware base.
  localparam logic [ADDR_W-1:0] LAMP_DISP = 12'h024;
  localparam logic [ADDR_W-1:0] SW_LO_DISP = 12'h024;
  localparam logic [ADDR_W-1:0] SW_HI_DISP = 12'h025;
  localparam logic [ADDR_W-1:0] AUTODIAL_DISP = 12'h037;

  // Lamp drive level after reset: dark.
  localparam logic LAMP_OFF = 1'h1;
  // Read data when nothing is addressed.
  localparam logic RD_IDLE = 1'h0;

endpackage : psl_pkg

// ==== hw/psl_cru_if.sv ====
// Write side of the bit-addressed bus, shared by the lamp bits.
// Assumes all signals change on the rising edge of clock.
`timescale 1ns/100ps
`default_nettype none

interface psl_cru_if
  import psl_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b
);

  logic [ADDR_W-1:0] addr;
  logic wdata;
  logic we;

  modport host (input clock, input rst_b, output addr, output wdata, output we);
  modport lamp (input clock, input rst_b, input addr, input wdata, input we);

endinterface : psl_cru_if

`default_nettype wire

// ==== hw/psl_sync2.sv ====
// Two-stage synchroniser for a group of slow pin levels.
// Assumes the inputs are asynchronous to clock.
`timescale 1ns/100ps
`default_nettype none

module psl_sync2 #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Pin side and clock side.
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] level_q;
  logic [W-1:0] level_d;

  always_comb
  begin
    meta_d = pin;
    level_d = meta_q;
  end

  always_ff @(posedge clock)
  begin
    if (!rst_b)
    begin
      meta_q <= '0;
      level_q <= '0;
    end
    else
    begin
      meta_q <= meta_d;
      level_q <= level_d;
    end
  end

  assign level = level_q;

endmodule : psl_sync2

`default_nettype wire

// ==== hw/psl_lamp_bit.sv ====
// One write-only lamp bit at a fixed bit address, active low.
// Assumes the bus strobe is one cycle long and clocked by clock.
`timescale 1ns/100ps
`default_nettype none

module psl_lamp_bit
  import psl_pkg::*;
#(
  parameter logic [ADDR_W-1:0] BIT_ADDR = 12'h000
) (
  // Shared write bus.
  psl_cru_if.lamp bus,
  // Lamp drive, low lights the lamp.
  output logic lamp_b
);

  logic lamp_q;
  logic lamp_d;
  logic hit;

  assign hit = bus.we && (bus.addr == BIT_ADDR);

  always_comb
  begin
    lamp_d = lamp_q;
    if (hit)
    begin
      // A zero lights, a one darkens; otherwise the lamp holds.
      lamp_d = bus.wdata;
    end
  end

  always_ff @(posedge bus.clock)
  begin
    if (!bus.rst_b)
    begin
      lamp_q <= LAMP_OFF;
    end
    else
    begin
      lamp_q <= lamp_d;
    end
  end

  assign lamp_b = lamp_q;

  a_lamp_lights_on_zero: assert property (
    @(posedge bus.clock) disable iff (!bus.rst_b)
    (bus.we && bus.addr == BIT_ADDR && !bus.wdata) |=> !lamp_b)
    else $error("lamp not lit after writing zero");

  a_lamp_off_on_one: assert property (
    @(posedge bus.clock) disable iff (!bus.rst_b)
    (bus.we && bus.addr == BIT_ADDR && bus.wdata) |=> lamp_b)
    else $error("lamp not dark after writing one");

  a_lamp_holds_state: assert property (
    @(posedge bus.clock) disable iff (!bus.rst_b)
    !(bus.we && bus.addr == BIT_ADDR) |=> $stable(lamp_b))
    else $error("lamp changed without a write to its bit");

endmodule : psl_lamp_bit

`default_nettype wire

// ==== bench/psl_host_model.sv ====
// Host model: bus master of the bit-addressed bus.
// Assumes the device answers a read in the cycle after the strobe.
`timescale 1ns/100ps
`default_nettype none

module psl_host_model (
  // Clock.
  input wire logic clock,
  // Bit bus toward the device.
  output var logic [psl_pkg::ADDR_W-1:0] cru_addr,
  output var logic cru_wdata,
  output var logic cru_we,
  output var logic cru_re,
  input wire logic cru_rdata
);
  import psl_pkg::*;

  initial
  begin
    cru_addr = '0;
    cru_wdata = 1'h0;
    cru_we = 1'h0;
    cru_re = 1'h0;
  end

  // A released bus shows the inverse so a stale value never looks valid.
  task automatic write_bit(input logic [ADDR_W-1:0] a, input logic d);
    @(posedge clock);
    cru_addr <= a;
    cru_wdata <= d;
    cru_we <= 1'h1;
    @(posedge clock);
    cru_we <= 1'h0;
    cru_addr <= ~a;
    cru_wdata <= ~d;
  endtask : write_bit

  task automatic read_bit(input logic [ADDR_W-1:0] a, output logic d);
    @(posedge clock);
    cru_addr <= a;
    cru_re <= 1'h1;
    @(posedge clock);
    cru_re <= 1'h0;
    cru_addr <= ~a;
    #1;
    d = cru_rdata;
  endtask : read_bit

  // A write and a read on back-to-back strobes, with no idle cycle between.
  task automatic write_then_read(input logic [ADDR_W-1:0] wa, input logic wd,
    input logic [ADDR_W-1:0] ra, output logic d);
    @(posedge clock);
    cru_addr <= wa;
    cru_wdata <= wd;
    cru_we <= 1'h1;
    @(posedge clock);
    cru_we <= 1'h0;
    cru_wdata <= ~wd;
    cru_addr <= ra;
    cru_re <= 1'h1;
    @(posedge clock);
    cru_re <= 1'h0;
    cru_addr <= ~ra;
    #1;
    d = cru_rdata;
  endtask : write_then_read

endmodule : psl_host_model

`default_nettype wire

// ==== bench/psl_port_bits_bench.sv ====
// Self-checking bench for the lamp and option-switch bits.
// Assumes the host model masters the bus; the bench drives the switches.
`timescale 1ns/100ps
`default_nettype none

module psl_port_bits_bench;
  import psl_pkg::*;

  logic clock;
  logic rst_b;
  logic [ADDR_W-1:0] cru_addr;
  logic cru_wdata;
  logic cru_we;
  logic cru_re;
  logic cru_rdata;
  logic [SW_W-1:0] option_switch_pack;
  logic [4:0] lamp_b;
  logic [4:0] exp_lamp;
  logic [7:0] pat;
  logic rd;
  int fail_count;
  int num_checks;
  logic [ADDR_W-1:0] base [NUM_PORTS] = '{PORT_A_BASE, PORT_B_BASE, PORT_C_BASE, PORT_D_BASE};

  psl_port_bits u_psl_port_bits (
    .clock(clock), .rst_b(rst_b), .cru_addr(cru_addr), .cru_wdata(cru_wdata),
    .cru_we(cru_we), .cru_re(cru_re), .cru_rdata(cru_rdata),
    .option_switch_pack(option_switch_pack), .port_a_lamp_b(lamp_b[0]),
    .port_b_lamp_b(lamp_b[1]), .port_c_lamp_b(lamp_b[2]), .port_d_lamp_b(lamp_b[3]),
    .autodial_lamp_b(lamp_b[4])
  );

  psl_host_model u_psl_host_model (
    .clock(clock), .cru_addr(cru_addr), .cru_wdata(cru_wdata), .cru_we(cru_we),
    .cru_re(cru_re), .cru_rdata(cru_rdata)
  );

  initial
  begin
    clock = 1'h0;
    forever #4 clock = ~clock;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic close_out();
    $display("Checks %0d, errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out

  // Walks every lamp back to dark and checks each step.
  task automatic all_dark();
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      u_psl_host_model.write_bit(base[p] + LAMP_DISP, 1'h1);
      exp_lamp[p] = 1'h1;
      #1;
      check({3'h0, lamp_b}, {3'h0, exp_lamp});
    end
    u_psl_host_model.write_bit(PORT_A_BASE + AUTODIAL_DISP, 1'h1);
    exp_lamp[4] = 1'h1;
    #1;
    check({3'h0, lamp_b}, {3'h0, exp_lamp});
  endtask : all_dark

  // Hang guard.
  initial
  begin
    repeat (20000) @(posedge clock);
    fail_count++;
    close_out();
  end

  initial
  begin
    rst_b = 1'h0;
    option_switch_pack = 8'h00;
    fail_count = 0;
    num_checks = 0;
    exp_lamp = 5'h1f;
    repeat (5) @(posedge clock);
    rst_b <= 1'h1;
    #1;
    check({3'h0, lamp_b}, 8'h1f);
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      u_psl_host_model.write_bit(base[p] + SW_HI_DISP, 1'h0);
      u_psl_host_model.write_bit(base[p] + LAMP_DISP - 12'h001, 1'h0);
      #1;
      check({3'h0, lamp_b}, {3'h0, exp_lamp});
      u_psl_host_model.write_bit(base[p] + LAMP_DISP, 1'h0);
      exp_lamp[p] = 1'h0;
      #1;
      check({3'h0, lamp_b}, {3'h0, exp_lamp});
    end
    u_psl_host_model.write_bit(PORT_A_BASE + AUTODIAL_DISP, 1'h0);
    exp_lamp[4] = 1'h0;
    #1;
    check({3'h0, lamp_b}, {3'h0, exp_lamp});
    for (int k = 0; k < 2; k++)
    begin
      pat = (k == 0) ? 8'h5a : 8'ha5;
      @(posedge clock);
      option_switch_pack <= pat;
      repeat (3) @(posedge clock);
      for (int p = 0; p < NUM_PORTS; p++)
      begin
        u_psl_host_model.read_bit(base[p] + SW_LO_DISP, rd);
        check({7'h0, rd}, {7'h0, pat[2*p]});
        u_psl_host_model.read_bit(base[p] + SW_HI_DISP, rd);
        check({7'h0, rd}, {7'h0, pat[2*p+1]});
      end
      u_psl_host_model.read_bit(PORT_A_BASE + AUTODIAL_DISP, rd);
      check({7'h0, rd}, 8'h00);
    end
    check({3'h0, lamp_b}, 8'h00);
    // A lamp write opposite to the switch, then a read of that bit at once.
    for (int p = 0; p < NUM_PORTS; p++)
    begin
      u_psl_host_model.write_then_read(base[p] + LAMP_DISP, ~pat[2*p],
        base[p] + SW_LO_DISP, rd);
      exp_lamp[p] = ~pat[2*p];
      check({7'h0, rd}, {7'h0, pat[2*p]});
      check({3'h0, lamp_b}, {3'h0, exp_lamp});
    end
    all_dark();
    close_out();
  end

endmodule : psl_port_bits_bench

`default_nettype wire
